// File: shared/dwdc_pkg.sv
// constants and types for the dac command word decoder and calibration core
package dwdc_pkg;
   localparam int NCH = 40;
   localparam int DW = 14;
   localparam int AW = 6;
   typedef logic [DW-1:0] dwdc_word_t;
   typedef logic [AW-1:0] dwdc_addr_t;
   // one command word as delivered by the serial front end
   typedef struct packed {
      logic rw;
      logic [1:0] reg_sel;
      dwdc_addr_t address;
      dwdc_word_t data;
   } dwdc_cmd_s;
   typedef logic [NCH-1:0][DW-1:0] dwdc_bank_t;
   localparam logic [1:0] SEL_INPUT = 2'h3;
   localparam logic [1:0] SEL_OFFSET = 2'h2;
   localparam logic [1:0] SEL_GAIN = 2'h1;
   localparam logic [1:0] SEL_SPECIAL = 2'h0;
   localparam dwdc_addr_t CMD_NO_OP = 6'h00;
   localparam dwdc_addr_t CMD_WR_CLEAR = 6'h01;
   localparam dwdc_addr_t CMD_SOFT_CLEAR = 6'h02;
   localparam dwdc_addr_t CMD_POWER_DOWN = 6'h08;
   localparam dwdc_addr_t CMD_POWER_UP = 6'h09;
   localparam dwdc_addr_t CMD_MONITOR = 6'h0A;
   localparam dwdc_addr_t CMD_CONTROL = 6'h0C;
   localparam dwdc_addr_t CMD_SOFT_RESET = 6'h0F;
   localparam dwdc_word_t GAIN_RST = 14'h3FFE;
   localparam dwdc_word_t OFFSET_RST = 14'h2000;
   localparam dwdc_word_t CLEAR_RST = 14'h0000;
   localparam dwdc_word_t CODE_RST = 14'h0000;
   localparam dwdc_word_t CTRL_RST = 14'h2000;
   localparam dwdc_addr_t MON_RST = 6'h00;
   localparam int CR_REF_LEVEL = 12;
   localparam int CR_REF_SOURCE = 10;
   localparam int MON_LSB = 8;
   localparam int FRAC_BITS = 14;
   localparam logic [16:0] GAIN_BIAS = 17'h00002;
   localparam logic [16:0] OFFSET_MID = 17'h02000;
   localparam logic [16:0] CODE_MAX = 17'h03FFF;
   localparam int CLK_MHZ = 25;
   localparam int SOFT_CLEAR_NS = 35000;
   localparam int SOFT_RESET_NS = 135000;
   localparam int SOFT_CLEAR_CYC = SOFT_CLEAR_NS * CLK_MHZ / 1000;
   localparam int SOFT_RESET_CYC = SOFT_RESET_NS * CLK_MHZ / 1000;
   localparam int BW = 12;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CLEARING = 3'b010,
      ST_RESETTING = 3'b100
   } dwdc_state_e;
endpackage : dwdc_pkg

// File: hdl/dwdc_core.sv
// command word decoder, calibration arithmetic and double-buffered code banks
//
// Operation
// - forty channels, each holding a 14-bit straight binary code in its own registers
// - control bit picks internal or external reference; level bit matters only internally
// - first-stage code per channel, all moved to converter stage on load pin
// - converter code equals ((gain+2)/2^14)*input plus offset minus 2^13
// - gain coefficient of every channel resets to 0x3FFE
// - gain uses bits 13 down to 1; bit 0 is always taken as zero
// - offset coefficient of every channel resets to 0x2000, meaning zero offset
// - select bits route data: 11 input, 10 offset, 01 gain, 00 special command
// - input data is straight binary, zero to 16383 of 16384
// - offset is offset binary: all ones +8191, 0x2000 zero, all zeros -8192
// - gain scales linearly, 0x3FFE meaning unity and zero meaning a gain of 2/16384
// - special space decodes six address bits into the listed commands
// - address 001100 writes control when rw is 0, reads it when 1
// - write-clear-code stores data in clear register, zero after power-up
// - soft clear loads all converter codes from clear register, busy low 35 us
// - soft reset restores defaults, clears converter codes, busy low 135 us
// - during soft or pin power-down the load pin still moves codes to the converter stage, other registers hold and all writes except power-up are refused
`timescale 1ns/1ps
`default_nettype none
module dwdc_core (
   input wire logic clock_in,                        // 25 MHz core clock
   input wire logic srst_in,                         // synchronous reset, active high
   input wire logic ce_in,                           // clock enable, freezes all state when low
   input wire logic cmd_valid_in,                    // command word present this cycle
   input wire dwdc_pkg::dwdc_cmd_s cmd_in,           // decoded serial command word
   input wire logic load_outputs_pin_n_in,           // load-outputs pin, active low, asynchronous
   input wire logic power_down_pin_in,               // hardware power-down pin, asynchronous
   output var logic cmd_ready_out,                   // commands are taken while high
   output var logic busy_n_out,                      // low while soft clear or soft reset runs
   output var logic read_valid_out,                  // one-cycle pulse with control readback
   output var dwdc_pkg::dwdc_word_t read_data_out,   // control register readback
   output var dwdc_pkg::dwdc_word_t ctrl_out,        // whole control register
   output var logic ref_internal_out,                // internal reference chosen
   output var logic ref_level_high_out,              // high internal level, internal source only
   output var logic powered_down_out,                // soft or pin power-down active
   output var dwdc_pkg::dwdc_addr_t monitor_chan_out, // channel routed to the monitor
   output var dwdc_pkg::dwdc_bank_t dac_code_out     // converter-stage codes of all channels
);
   import dwdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic load_meta_reg;
   logic load_sync_reg;
   logic pd_meta_reg;
   logic pd_sync_reg;

   // pins idle inactive in reset so no false load or power-down follows it
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         load_meta_reg <= 1'b1;
         load_sync_reg <= 1'b1;
      end else if (ce_in) begin
         load_meta_reg <= load_outputs_pin_n_in;
         load_sync_reg <= load_meta_reg;
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pd_meta_reg <= 1'b0;
         pd_sync_reg <= 1'b0;
      end else if (ce_in) begin
         pd_meta_reg <= power_down_pin_in;
         pd_sync_reg <= pd_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command decode

   dwdc_state_e state_reg;
   dwdc_state_e state_next;
   logic [BW-1:0] busy_cnt_reg;
   logic [BW-1:0] busy_cnt_next;
   logic soft_pd_reg;
   dwdc_word_t clear_code_reg;
   dwdc_word_t ctrl_reg;
   dwdc_addr_t monitor_reg;
   dwdc_bank_t gain_reg;
   dwdc_bank_t offset_reg;
   dwdc_bank_t pend_reg;

   wire pd_active = soft_pd_reg | pd_sync_reg;
   // a command is only taken between busy periods
   wire cmd_take = cmd_valid_in & ce_in & (state_reg == ST_IDLE);
   wire wr_ok = cmd_take & ~pd_active;
   wire is_special = cmd_in.reg_sel == SEL_SPECIAL;
   wire is_input = cmd_in.reg_sel == SEL_INPUT;
   wire is_offset = cmd_in.reg_sel == SEL_OFFSET;
   wire is_gain = cmd_in.reg_sel == SEL_GAIN;
   wire sp_wr = wr_ok & is_special & ~cmd_in.rw;
   // unlisted addresses match none of these and fall through untouched
   wire do_wr_clear = sp_wr & (cmd_in.address == CMD_WR_CLEAR);
   wire do_soft_clear = sp_wr & (cmd_in.address == CMD_SOFT_CLEAR);
   wire do_pd = sp_wr & (cmd_in.address == CMD_POWER_DOWN);
   wire do_monitor = sp_wr & (cmd_in.address == CMD_MONITOR);
   wire do_ctrl_wr = sp_wr & (cmd_in.address == CMD_CONTROL);
   wire do_soft_reset = sp_wr & (cmd_in.address == CMD_SOFT_RESET);
   // power-up must get through while powered down, so it bypasses the write gate
   wire do_pu = cmd_take & is_special & ~cmd_in.rw & (cmd_in.address == CMD_POWER_UP);
   wire do_ctrl_rd = cmd_take & is_special & cmd_in.rw & (cmd_in.address == CMD_CONTROL);
   wire load_now = ce_in & ~load_sync_reg;
   wire wipe = srst_in | do_soft_reset;

   ////////////////////////////////////////////////////////////////////////////
   // calibration arithmetic, one shared datapath for the addressed channel

   wire addr_ok = cmd_in.address < AW'(NCH);
   wire dwdc_addr_t ch_idx = addr_ok ? cmd_in.address : MON_RST;
   wire dwdc_word_t sel_gain = gain_reg[ch_idx];
   wire dwdc_word_t sel_offset = offset_reg[ch_idx];
   // a host that leaves bit 0 set must not skew the gain
   wire dwdc_word_t gain_masked = {cmd_in.data[DW-1:1], 1'b0};
   // gain + 2 needs 15 bits; product of 15 x 14 bits fits in 29
   wire [16:0] gain_plus = {3'h0, sel_gain} + GAIN_BIAS;
   wire [30:0] product = gain_plus[14:0] * {17'h00000, cmd_in.data};
   wire [16:0] scaled = {2'h0, product[FRAC_BITS +: 15]};
   // offset binary: subtracting midscale makes it a signed correction
   wire [16:0] sum = scaled + {3'h0, sel_offset} - OFFSET_MID;
   wire neg = sum[16];
   wire over = ~neg & (sum > CODE_MAX);
   wire dwdc_word_t corrected = neg ? CODE_RST : (over ? CODE_MAX[DW-1:0] : sum[DW-1:0]);

   ////////////////////////////////////////////////////////////////////////////
   // per-channel registers

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      wire hit = wr_ok & addr_ok & (cmd_in.address == AW'(i));
      wire hit_gain = hit & is_gain;
      wire hit_offset = hit & is_offset;
      wire hit_input = hit & is_input;

      always_ff @(posedge clock_in) begin
         if (wipe) begin
            gain_reg[i] <= GAIN_RST;
         end else if (hit_gain) begin
            gain_reg[i] <= gain_masked;
         end
      end

      always_ff @(posedge clock_in) begin
         if (wipe) begin
            offset_reg[i] <= OFFSET_RST;
         end else if (hit_offset) begin
            offset_reg[i] <= cmd_in.data;
         end
      end

      // code is fixed when written; later coefficient writes do not redo it
      always_ff @(posedge clock_in) begin
         if (wipe) begin
            pend_reg[i] <= CODE_RST;
         end else if (hit_input) begin
            pend_reg[i] <= corrected;
         end
      end

      // clear wins over a coincident load so the clear code is what lands
      always_ff @(posedge clock_in) begin
         if (wipe) begin
            dac_code_out[i] <= CODE_RST;
         end else if (do_soft_clear) begin
            dac_code_out[i] <= clear_code_reg;
         end else if (load_now) begin
            dac_code_out[i] <= pend_reg[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // busy sequencing

   always_comb begin
      state_next = state_reg;
      busy_cnt_next = busy_cnt_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (do_soft_reset) begin
               state_next = ST_RESETTING;
               busy_cnt_next = BW'(SOFT_RESET_CYC - 1);
            end else if (do_soft_clear) begin
               state_next = ST_CLEARING;
               busy_cnt_next = BW'(SOFT_CLEAR_CYC - 1);
            end
         end
         ST_CLEARING, ST_RESETTING: begin
            if (busy_cnt_reg == '0) begin
               state_next = ST_IDLE;
            end else begin
               busy_cnt_next = busy_cnt_reg - 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
            busy_cnt_next = '0;
         end
      endcase
   end

   wire idle_next = state_next == ST_IDLE;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_reg <= ST_IDLE;
         busy_cnt_reg <= '0;
         busy_n_out <= 1'b1;
         cmd_ready_out <= 1'b1;
      end else if (ce_in) begin
         state_reg <= state_next;
         busy_cnt_reg <= busy_cnt_next;
         busy_n_out <= idle_next;
         cmd_ready_out <= idle_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // special-function registers

   always_ff @(posedge clock_in) begin
      if (wipe) begin
         clear_code_reg <= CLEAR_RST;
      end else if (do_wr_clear) begin
         clear_code_reg <= cmd_in.data;
      end
   end

   // reference bits reach the pins through the registered outputs a cycle later
   always_ff @(posedge clock_in) begin
      if (wipe) begin
         ctrl_reg <= CTRL_RST;
      end else if (do_ctrl_wr) begin
         ctrl_reg <= cmd_in.data;
      end
   end

   always_ff @(posedge clock_in) begin
      if (wipe) begin
         monitor_reg <= MON_RST;
      end else if (do_monitor) begin
         monitor_reg <= cmd_in.data[MON_LSB +: AW];
      end
   end

   // power-up is decoded outside the write gate so it still gets through
   always_ff @(posedge clock_in) begin
      if (wipe) begin
         soft_pd_reg <= 1'b0;
      end else if (do_pd) begin
         soft_pd_reg <= 1'b1;
      end else if (do_pu) begin
         soft_pd_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs

   wire ref_level_sel = ctrl_reg[CR_REF_SOURCE] & ctrl_reg[CR_REF_LEVEL];

   // readback strobe lasts one cycle; the data stays until the next read
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         read_valid_out <= 1'b0;
         read_data_out <= CODE_RST;
      end else if (ce_in) begin
         read_valid_out <= do_ctrl_rd;
         if (do_ctrl_rd) begin
            read_data_out <= ctrl_reg;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctrl_out <= CTRL_RST;
         ref_internal_out <= CTRL_RST[CR_REF_SOURCE];
         ref_level_high_out <= 1'b0;
      end else if (ce_in) begin
         ctrl_out <= ctrl_reg;
         ref_internal_out <= ctrl_reg[CR_REF_SOURCE];
         ref_level_high_out <= ref_level_sel;
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         powered_down_out <= 1'b0;
         monitor_chan_out <= MON_RST;
      end else if (ce_in) begin
         powered_down_out <= pd_active;
         monitor_chan_out <= monitor_reg;
      end
   end
endmodule : dwdc_core
`default_nettype wire

// File: testbench/dwdc_core_assertions.sv
// port assertions for the command decoder core
`timescale 1ns/1ps
`default_nettype none
module dwdc_core_assertions (
   input wire logic clock_in, // clock
   input wire logic srst_in, // reset
   input wire logic ce_in, // enable
   input wire logic cmd_valid_in, // word valid
   input wire dwdc_pkg::dwdc_cmd_s cmd_in, // word
   input wire logic load_outputs_pin_n_in, // load pin
   input wire logic power_down_pin_in, // pd pin
   input wire logic cmd_ready_out, // ready
   input wire logic busy_n_out, // busy
   input wire logic read_valid_out, // strobe
   input wire dwdc_pkg::dwdc_word_t ctrl_out, // control
   input wire logic ref_internal_out, // source
   input wire logic ref_level_high_out, // level
   input wire logic powered_down_out, // down
   input wire dwdc_pkg::dwdc_bank_t dac_code_out // codes
);
   import dwdc_pkg::*;
   logic [2:0] age_reg;
   logic [11:0] low_reg;
   wire logic acc = cmd_valid_in && cmd_ready_out && ce_in;
   wire logic spw = acc && cmd_in.reg_sel == SEL_SPECIAL && !cmd_in.rw && !powered_down_out;
   // age keeps pin checks clear of synchronisers still holding reset values
   always_ff @(posedge clock_in) begin
      age_reg <= srst_in ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
      low_reg <= busy_n_out ? 12'h000 : low_reg + 12'h001;
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   a_read_pulse:
      assert property (acc && cmd_in.reg_sel == SEL_SPECIAL && cmd_in.address == CMD_CONTROL && cmd_in.rw
         |=> read_valid_out) else $error("no read strobe");
   a_clear_busy:
      assert property (spw && (cmd_in.address == CMD_SOFT_CLEAR || cmd_in.address == CMD_SOFT_RESET)
         |=> !busy_n_out && !cmd_ready_out) else $error("busy not raised");
   a_busy_max:
      assert property (low_reg <= 12'hD31) else $error("busy too long");
   a_busy_min:
      assert property (age_reg != 3'h0 && $rose(busy_n_out) |-> $past(low_reg) >= 12'h369)
         else $error("busy too short");
   a_ready_busy:
      assert property (!busy_n_out |-> !cmd_ready_out) else $error("ready while busy");
   a_ref_level:
      assert property (ref_level_high_out |-> ref_internal_out) else $error("level without source");
   a_ctrl_write:
      assert property (spw && cmd_in.address == CMD_CONTROL ##1 !cmd_valid_in && ce_in
         |=> ctrl_out == $past(cmd_in.data, 2)) else $error("control not written");
   a_dac_hold:
      assert property (age_reg == 3'h7 && busy_n_out && $past(busy_n_out) && $past(load_outputs_pin_n_in)
         && $past(load_outputs_pin_n_in, 2) && $past(load_outputs_pin_n_in, 3) |-> $stable(dac_code_out))
         else $error("codes moved without load");
   a_pd_pin:
      assert property (age_reg == 3'h7 && $past(power_down_pin_in, 3) && $past(power_down_pin_in, 4)
         |-> powered_down_out) else $error("pin power-down missed");
endmodule : dwdc_core_assertions
bind dwdc_core dwdc_core_assertions u_chk (.clock_in(clock_in), .srst_in(srst_in), .ce_in(ce_in),
   .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .load_outputs_pin_n_in(load_outputs_pin_n_in),
   .power_down_pin_in(power_down_pin_in), .cmd_ready_out(cmd_ready_out), .busy_n_out(busy_n_out),
   .read_valid_out(read_valid_out), .ctrl_out(ctrl_out), .ref_internal_out(ref_internal_out),
   .ref_level_high_out(ref_level_high_out), .powered_down_out(powered_down_out), .dac_code_out(dac_code_out));
`default_nettype wire

// File: testbench/dwdc_host_model.sv
// host model issuing command words to the core
`timescale 1ns/1ps
`default_nettype none
module dwdc_host_model (
   input wire logic clock_in, // clock
   input wire logic ready_in, // core takes words
   output var logic cmd_valid_out, // word present
   output var dwdc_pkg::dwdc_cmd_s cmd_out // word
);
   import dwdc_pkg::*;
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out = '0;
   end
   // held until a ready edge; bit 0 of gain words left as given so the core's masking is seen
   task automatic send(input logic rw, input logic [1:0] sel, input dwdc_addr_t adr, input dwdc_word_t dat);
      @(posedge clock_in);
      cmd_valid_out <= 1'b1;
      cmd_out <= {rw, sel, adr, dat};
      @(posedge clock_in);
      while (ready_in !== 1'b1) @(posedge clock_in);
      cmd_valid_out <= 1'b0;
      cmd_out <= ~cmd_out;
   endtask : send
endmodule : dwdc_host_model
`default_nettype wire

// File: testbench/dwdc_core_test.sv
// self-checking bench for the command decoder core
`timescale 1ns/1ps
`default_nettype none
module dwdc_core_test;
   import dwdc_pkg::*;
   logic clock_in = 1'b0;
   logic srst_in = 1'b1;
   logic ld_n = 1'b1;
   logic pd_pin = 1'b0;
   logic ce = 1'b1;
   logic valid, ready, busy_n, rd_v, ref_i, ref_h, pdn;
   dwdc_cmd_s cmd;
   dwdc_word_t rd_d, ctrl;
   dwdc_addr_t mon;
   dwdc_bank_t dac;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #20 clock_in = ~clock_in;
   dwdc_host_model host (.clock_in(clock_in), .ready_in(ready), .cmd_valid_out(valid), .cmd_out(cmd));
   dwdc_core uut (.clock_in(clock_in), .srst_in(srst_in), .ce_in(ce), .cmd_valid_in(valid), .cmd_in(cmd),
      .load_outputs_pin_n_in(ld_n), .power_down_pin_in(pd_pin), .cmd_ready_out(ready), .busy_n_out(busy_n),
      .read_valid_out(rd_v), .read_data_out(rd_d), .ctrl_out(ctrl), .ref_internal_out(ref_i),
      .ref_level_high_out(ref_h), .powered_down_out(pdn), .monitor_chan_out(mon), .dac_code_out(dac));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   task automatic wr(input logic [1:0] s, input dwdc_addr_t a, input dwdc_word_t d);
      host.send(1'b0, s, a, d);
   endtask : wr
   // four edges low so the pin gets past its synchroniser
   task automatic load;
      @(posedge clock_in);
      ld_n <= 1'b0;
      repeat (4) @(posedge clock_in);
      ld_n <= 1'b1;
      tick(3);
   endtask : load
   task automatic busy_len(input int n);
      int k;
      k = 0;
      #1;
      while (busy_n !== 1'b1 && k < 4000) begin
         tick(1);
         k++;
      end
      chk("busy length", 14'h0001, {13'h0, k >= n - 2 && k <= n + 2});
   endtask : busy_len
   task automatic t_codes;
      chk("ctrl reset", CTRL_RST, ctrl);
      wr(SEL_INPUT, 6'h05, 14'h1234);
      wr(SEL_INPUT, 6'h27, 14'h3FFF);
      wr(SEL_GAIN, 6'h07, 14'h1FFF);
      wr(SEL_OFFSET, 6'h07, 14'h2064);
      wr(SEL_INPUT, 6'h07, 14'h3FFF);
      wr(SEL_OFFSET, 6'h08, 14'h3FFF);
      wr(SEL_INPUT, 6'h08, 14'h3FFF);
      wr(SEL_OFFSET, 6'h09, 14'h0000);
      wr(SEL_INPUT, 6'h09, 14'h0010);
      tick(3);
      chk("before load", 14'h0000, dac[5]);
      load;
      chk("unity", 14'h1234, dac[5]);
      chk("top", 14'h3FFF, dac[39]);
      chk("half gain", 14'h2063, dac[7]);
      chk("high clamp", 14'h3FFF, dac[8]);
      chk("low clamp", 14'h0000, dac[9]);
      $display("test codes done");
   endtask : t_codes
   task automatic t_special;
      wr(SEL_SPECIAL, CMD_CONTROL, 14'h1400);
      host.send(1'b1, SEL_SPECIAL, CMD_CONTROL, 14'h0000);
      #1;
      chk("read data", 14'h1401, {rd_d[13:1], rd_v});
      tick(1);
      chk("ref bits", 14'h0003, {12'h0, ref_i, ref_h});
      wr(SEL_SPECIAL, CMD_CONTROL, 14'h1000);
      wr(SEL_SPECIAL, 6'h3F, 14'h3FFF);
      host.send(1'b1, SEL_SPECIAL, CMD_NO_OP, 14'h3FFF);
      wr(SEL_SPECIAL, CMD_MONITOR, 14'h0700);
      tick(2);
      chk("level ignored", 14'h0000, {12'h0, ref_i, ref_h});
      chk("ctrl kept", 14'h1000, ctrl);
      chk("monitor", 14'h0007, {8'h0, mon});
      wr(SEL_SPECIAL, CMD_WR_CLEAR, 14'h0ABC);
      wr(SEL_SPECIAL, CMD_SOFT_CLEAR, 14'h0000);
      busy_len(SOFT_CLEAR_CYC);
      chk("cleared", 14'h0ABC, dac[39]);
      $display("test special done");
   endtask : t_special
   task automatic t_power;
      wr(SEL_SPECIAL, CMD_POWER_DOWN, 14'h0000);
      wr(SEL_INPUT, 6'h05, 14'h0001);
      #1;
      chk("soft down", 14'h0001, {13'h0, pdn});
      wr(SEL_SPECIAL, CMD_POWER_UP, 14'h0000);
      @(posedge clock_in);
      pd_pin <= 1'b1;
      tick(5);
      chk("pin down", 14'h0001, {13'h0, pdn});
      wr(SEL_INPUT, 6'h05, 14'h0003);
      @(posedge clock_in);
      pd_pin <= 1'b0;
      tick(5);
      load;
      chk("writes refused", 14'h1234, dac[5]);
      wr(SEL_SPECIAL, CMD_SOFT_RESET, 14'h0000);
      busy_len(SOFT_RESET_CYC);
      chk("reset code", 14'h0000, dac[5]);
      chk("reset ctrl", CTRL_RST, ctrl);
      wr(SEL_INPUT, 6'h07, 14'h0100);
      load;
      chk("defaults back", 14'h0100, dac[7]);
      // enable low must freeze the load path even with the pin held low
      wr(SEL_INPUT, 6'h07, 14'h0200);
      @(posedge clock_in);
      ce <= 1'b0;
      ld_n <= 1'b0;
      tick(6);
      chk("frozen by enable", 14'h0100, dac[7]);
      @(posedge clock_in);
      ld_n <= 1'b1;
      ce <= 1'b1;
      tick(3);
      chk("no late load", 14'h0100, dac[7]);
      load;
      chk("load after enable", 14'h0200, dac[7]);
      $display("test power done");
   endtask : t_power
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         fail_count++;
         end_sim;
      end
   end
   initial begin
      repeat (12) @(posedge clock_in);
      srst_in <= 1'b0;
      tick(2);
      t_codes;
      t_special;
      t_power;
      end_sim;
   end
endmodule : dwdc_core_test
`default_nettype wire
